// ---- common/pirq_regs.vh ----
// peripheral interrupt routing: line positions, widths and polarity levels
// assumes inclusion by the routing design files only
`ifndef PIRQ_REGS_VH
`define PIRQ_REGS_VH

// controller base address seen by software
`define PIRQ_CTRL_BASE        32'hF000_0000

// widths
`define PIRQ_SHARED_W         128
`define PIRQ_PRIV_W           4
`define PIRQ_NUM_UART         6
`define PIRQ_GPIO_PINS        16

// shared line positions
`define PIRQ_SH_WDG           0
`define PIRQ_SH_TMR1          1
`define PIRQ_SH_TMR2          2
`define PIRQ_SH_TMRC          3
`define PIRQ_SH_RTC           4
`define PIRQ_SH_U2_RX         5
`define PIRQ_SH_U2_TX         6
`define PIRQ_SH_U3_RX         7
`define PIRQ_SH_U3_TX         8
`define PIRQ_SH_U4_RX         9
`define PIRQ_SH_U4_TX         10
`define PIRQ_SH_U5_RX         11
`define PIRQ_SH_U5_TX         12
`define PIRQ_SH_U2_COMB       13
`define PIRQ_SH_UOVF          17
`define PIRQ_SH_ETH           18
`define PIRQ_SH_USB           19
`define PIRQ_SH_AUDIO         20
`define PIRQ_SH_TOUCH         21
`define PIRQ_SH_ADC           22
`define PIRQ_SH_SPI0          23
`define PIRQ_SH_SPI1          24
`define PIRQ_SH_LCD           25
`define PIRQ_SH_GPIO_COMB     26
`define PIRQ_SH_GPIO_PIN      30
`define PIRQ_SH_USED_TOP      93

// private line positions
`define PIRQ_PV_RX            0
`define PIRQ_PV_TX            1
`define PIRQ_PV_COMB          2
`define PIRQ_PV_OVF           3

// reset values: shared inactive low, private inactive high
`define PIRQ_SHARED_RST       128'h0000_0000_0000_0000_0000_0000_0000_0000
`define PIRQ_PRIV_RST         4'hF

`endif

// ---- core/pirq_sync.v ----
// two-flop synchroniser for a vector of asynchronous request levels
// assumes sources may come from other clock domains
`timescale 1ns/100ps
`default_nettype none

module pirq_sync #(
  parameter W = 1
) (
  input  wire         core_clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // pirq_sync

`default_nettype wire

// ---- core/pirq_router.v ----
// peripheral interrupt router: maps peripheral requests onto shared and private lines
// assumes active-high request levels from all peripherals, one clock core_clk
//
// Summary of operation
// - shared lines are driven active high, private lines active low.
// - the receiving controller sits at base address 0xF000_0000 in the cluster.
// - each of the six uarts delivers tx, rx, tx overrun, rx overrun and combined requests.
// - each uart's tx, rx and combined requests get dedicated controller lines.
// - a uart's two overrun requests are ored into one overflow request.
// - uart 0 rx, tx, combined, overflow drive private group 0 bits 0 to 3.
// - uart 1 rx, tx, combined, overflow drive private group 1 bits 0 to 3.
// - uart 2 rx and tx drive shared lines 5 and 6.
// - uart 3 rx and tx drive shared lines 7 and 8.
// - uart 4 rx and tx drive shared lines 9 and 10.
// - uart 5 rx and tx drive shared lines 11 and 12.
// - combined requests of uarts 2 to 5 drive shared lines 13 to 16.
// - overflow requests of uarts 2 to 5 are ored onto shared line 17.
// - gpio port 0 to 3 combined requests drive shared lines 26 to 29.
// - gpio ports 0, 1, 2 pin requests drive shared 30-45, 46-61, 62-77.
// - gpio port 3 pin requests drive shared lines 78 to 93.
`timescale 1ns/100ps
`default_nettype none
`include "pirq_regs.vh"

module pirq_router #(
  parameter NUM_UART  = 6,
  parameter GPIO_PINS = 16,
  parameter SHARED_W  = 128,
  parameter [31:0] CTRL_BASE = `PIRQ_CTRL_BASE
) (
  input  wire                      core_clk,
  input  wire                      rst,
  input  wire [NUM_UART-1:0]       uart_tx_request,
  input  wire [NUM_UART-1:0]       uart_rx_request,
  input  wire [NUM_UART-1:0]       uart_tx_overrun_request,
  input  wire [NUM_UART-1:0]       uart_rx_overrun_request,
  input  wire [NUM_UART-1:0]       uart_combined_request,
  input  wire [3:0]                gpio_combined_request,
  input  wire [GPIO_PINS-1:0]      gpio0_pin_request,
  input  wire [GPIO_PINS-1:0]      gpio1_pin_request,
  input  wire [GPIO_PINS-1:0]      gpio2_pin_request,
  input  wire [GPIO_PINS-1:0]      gpio3_pin_request,
  input  wire                      watchdog_request,
  input  wire                      timer1_request,
  input  wire                      timer2_request,
  input  wire                      timer_combined_request,
  input  wire                      rtc_request,
  input  wire                      ethernet_request,
  input  wire                      usb_request,
  input  wire                      audio_request,
  input  wire                      touch_request,
  input  wire                      adc_spi_request,
  input  wire                      shield0_spi_request,
  input  wire                      shield1_spi_request,
  input  wire                      lcd_request,
  output reg  [SHARED_W-1:0]       shared_irq,
  output reg  [3:0]                private_irq_group0_n,
  output reg  [3:0]                private_irq_group1_n
);

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  // controller base address
  // CTRL_BASE only records where software reaches the controller; no line depends on it

  localparam NSYNC = 5 * NUM_UART + 4 + 4 * GPIO_PINS + 13;

  wire [NSYNC-1:0] raw_in;
  wire [NSYNC-1:0] syn_in;

  assign raw_in = {uart_tx_request, uart_rx_request, uart_tx_overrun_request,
                   uart_rx_overrun_request, uart_combined_request,
                   gpio_combined_request, gpio3_pin_request, gpio2_pin_request,
                   gpio1_pin_request, gpio0_pin_request,
                   watchdog_request, timer1_request, timer2_request,
                   timer_combined_request, rtc_request, ethernet_request,
                   usb_request, audio_request, touch_request, adc_spi_request,
                   shield0_spi_request, shield1_spi_request, lcd_request};

  // requests come from peripherals on other clocks, so resynchronise all
  pirq_sync #(
    .W (NSYNC)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (raw_in),
    .q        (syn_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  // unpack synchronised requests

  localparam O_MISC = 0;
  localparam O_GP0  = 13;
  localparam O_GP1  = O_GP0 + GPIO_PINS;
  localparam O_GP2  = O_GP1 + GPIO_PINS;
  localparam O_GP3  = O_GP2 + GPIO_PINS;
  localparam O_GPC  = O_GP3 + GPIO_PINS;
  localparam O_UC   = O_GPC + 4;
  localparam O_URO  = O_UC + NUM_UART;
  localparam O_UTO  = O_URO + NUM_UART;
  localparam O_URX  = O_UTO + NUM_UART;
  localparam O_UTX  = O_URX + NUM_UART;

  wire [NUM_UART-1:0]  s_utx  = syn_in[O_UTX +: NUM_UART];
  wire [NUM_UART-1:0]  s_urx  = syn_in[O_URX +: NUM_UART];
  wire [NUM_UART-1:0]  s_uto  = syn_in[O_UTO +: NUM_UART];
  wire [NUM_UART-1:0]  s_uro  = syn_in[O_URO +: NUM_UART];
  wire [NUM_UART-1:0]  s_ucmb = syn_in[O_UC  +: NUM_UART];
  wire [3:0]           s_gpc  = syn_in[O_GPC +: 4];
  wire [12:0]          s_misc = syn_in[O_MISC +: 13];

  // per-uart overflow is the or of both overruns
  wire [NUM_UART-1:0]  uart_ovf = s_uto | s_uro;

  //////////////////////////////////////////////////////////////////////////////
  // shared line map, combinational

  reg [SHARED_W-1:0] shared_nxt;

  always @* begin
    shared_nxt = `PIRQ_SHARED_RST;
    shared_nxt[`PIRQ_SH_WDG]   = s_misc[12];
    shared_nxt[`PIRQ_SH_TMR1]  = s_misc[11];
    shared_nxt[`PIRQ_SH_TMR2]  = s_misc[10];
    shared_nxt[`PIRQ_SH_TMRC]  = s_misc[9];
    shared_nxt[`PIRQ_SH_RTC]   = s_misc[8];
    shared_nxt[`PIRQ_SH_U2_RX] = s_urx[2];
    shared_nxt[`PIRQ_SH_U2_TX] = s_utx[2];
    shared_nxt[`PIRQ_SH_U3_RX] = s_urx[3];
    shared_nxt[`PIRQ_SH_U3_TX] = s_utx[3];
    shared_nxt[`PIRQ_SH_U4_RX] = s_urx[4];
    shared_nxt[`PIRQ_SH_U4_TX] = s_utx[4];
    shared_nxt[`PIRQ_SH_U5_RX] = s_urx[5];
    shared_nxt[`PIRQ_SH_U5_TX] = s_utx[5];
    shared_nxt[`PIRQ_SH_U2_COMB +: 4] = s_ucmb[5:2];
    shared_nxt[`PIRQ_SH_UOVF]  = |uart_ovf[5:2];
    shared_nxt[`PIRQ_SH_ETH]   = s_misc[7];
    shared_nxt[`PIRQ_SH_USB]   = s_misc[6];
    shared_nxt[`PIRQ_SH_AUDIO] = s_misc[5];
    shared_nxt[`PIRQ_SH_TOUCH] = s_misc[4];
    shared_nxt[`PIRQ_SH_ADC]   = s_misc[3];
    shared_nxt[`PIRQ_SH_SPI0]  = s_misc[2];
    shared_nxt[`PIRQ_SH_SPI1]  = s_misc[1];
    shared_nxt[`PIRQ_SH_LCD]   = s_misc[0];
    shared_nxt[`PIRQ_SH_GPIO_COMB +: 4] = s_gpc;
    shared_nxt[`PIRQ_SH_GPIO_PIN +: GPIO_PINS]                 = syn_in[O_GP0 +: GPIO_PINS];
    shared_nxt[`PIRQ_SH_GPIO_PIN + GPIO_PINS +: GPIO_PINS]     = syn_in[O_GP1 +: GPIO_PINS];
    shared_nxt[`PIRQ_SH_GPIO_PIN + 2 * GPIO_PINS +: GPIO_PINS] = syn_in[O_GP2 +: GPIO_PINS];
    shared_nxt[`PIRQ_SH_GPIO_PIN + 3 * GPIO_PINS +: GPIO_PINS] = syn_in[O_GP3 +: GPIO_PINS];
  end

  //////////////////////////////////////////////////////////////////////////////
  // private groups, active low

  wire [3:0] priv0_nxt = ~{uart_ovf[0], s_ucmb[0], s_utx[0], s_urx[0]};
  wire [3:0] priv1_nxt = ~{uart_ovf[1], s_ucmb[1], s_utx[1], s_urx[1]};

  //////////////////////////////////////////////////////////////////////////////
  // output registers; reset leaves every line inactive

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shared_irq           <= `PIRQ_SHARED_RST;
      private_irq_group0_n <= `PIRQ_PRIV_RST;
      private_irq_group1_n <= `PIRQ_PRIV_RST;
    end else begin
      shared_irq           <= shared_nxt;
      private_irq_group0_n <= priv0_nxt;
      private_irq_group1_n <= priv1_nxt;
    end
  end

endmodule // pirq_router

`default_nettype wire

// ---- tb/pirq_router_monitor.sv ----
// checker for the interrupt router ports
// assumes rst is held with all requests low
`timescale 1ns/100ps
`default_nettype none
module pirq_router_monitor #(parameter NUM_UART = 6, GPIO_PINS = 16, SHARED_W = 128) (
  input wire logic [NUM_UART-1:0]  uart_tx_request,
  input wire logic [NUM_UART-1:0]  uart_rx_request,
  input wire logic [NUM_UART-1:0]  uart_tx_overrun_request,
  input wire logic [NUM_UART-1:0]  uart_rx_overrun_request,
  input wire logic [NUM_UART-1:0]  uart_combined_request,
  input wire logic [3:0]           gpio_combined_request,
  input wire logic [GPIO_PINS-1:0] gpio0_pin_request,
  input wire logic [GPIO_PINS-1:0] gpio1_pin_request,
  input wire logic [GPIO_PINS-1:0] gpio2_pin_request,
  input wire logic [GPIO_PINS-1:0] gpio3_pin_request,
  input wire logic [SHARED_W-1:0]  shared_irq,
  input wire logic [3:0]           private_irq_group0_n,
  input wire logic [3:0]           private_irq_group1_n,
  input wire logic                 core_clk,
  input wire logic                 rst);
  logic [1:0]          up_r;
  logic [NUM_UART-1:0] ovf;
  assign ovf = uart_tx_overrun_request | uart_rx_overrun_request;
  // three flops deep, so mapping only holds from the fourth edge after reset
  always @(posedge core_clk or posedge rst) begin
    if (rst) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rx0_held; $rose(uart_rx_request[0]) ##1 uart_rx_request[0] [*2]; endsequence
  rx0_latency_a : assert property (rx0_held |=> !private_irq_group0_n[0])
    else $error("uart0 rx not seen on private line");
  group0_map_a : assert property (up_r == 2'h3 |-> private_irq_group0_n == ~$past({ovf[0],
    uart_combined_request[0], uart_tx_request[0], uart_rx_request[0]}, 3)) else $error("group0");
  group1_map_a : assert property (up_r == 2'h3 |-> private_irq_group1_n == ~$past({ovf[1],
    uart_combined_request[1], uart_tx_request[1], uart_rx_request[1]}, 3)) else $error("group1");
  uart_shared_a : assert property (up_r == 2'h3 |-> shared_irq[12:5] == $past({
    uart_tx_request[5], uart_rx_request[5], uart_tx_request[4], uart_rx_request[4],
    uart_tx_request[3], uart_rx_request[3], uart_tx_request[2], uart_rx_request[2]}, 3))
    else $error("uart rx tx lines");
  uart_comb_a : assert property (up_r == 2'h3 |->
    shared_irq[16:13] == $past(uart_combined_request[5:2], 3)) else $error("uart combined");
  ovf_or_a : assert property (up_r == 2'h3 |-> shared_irq[17] == $past(|ovf[5:2], 3))
    else $error("overflow line");
  gpio_comb_a : assert property (up_r == 2'h3 |->
    shared_irq[29:26] == $past(gpio_combined_request, 3)) else $error("gpio combined");
  gpio_pins_a : assert property (up_r == 2'h3 |-> shared_irq[93:30] == $past({
    gpio3_pin_request, gpio2_pin_request, gpio1_pin_request, gpio0_pin_request}, 3))
    else $error("gpio pins");
  unused_low_a : assert property (shared_irq[SHARED_W-1:94] == '0) else $error("spare line");
endmodule // pirq_router_monitor
`default_nettype wire

// ---- tb/pirq_ctrl_model.sv ----
// controller-side model: routed lines turned into active-high pending flags
// assumes it sees the router outputs directly
`timescale 1ns/100ps
`default_nettype none
module pirq_ctrl_model #(parameter [31:0] BASE = 32'hF000_0000, parameter SHARED_W = 128) (
  input  wire logic [SHARED_W-1:0] shared_irq,
  input  wire logic [3:0]          private_irq_group0_n,
  input  wire logic [3:0]          private_irq_group1_n,
  output logic [SHARED_W+7:0]      pending);
  assign pending = {~private_irq_group1_n, ~private_irq_group0_n, shared_irq};
endmodule // pirq_ctrl_model
`default_nettype wire

// ---- tb/pirq_router_tb.sv ----
// testbench for the interrupt router
// assumes the controller model and checker sit beside the router
`timescale 1ns/100ps
`default_nettype none
module pirq_router_tb;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic [110:0] req = '0; // all request inputs, one bit each
  logic [127:0] shared_irq;
  logic [3:0]   private_irq_group0_n;
  logic [3:0]   private_irq_group1_n;
  logic [135:0] pending;
  int           errors = 0;
  int           samples_checked = 0;
  always #10 core_clk = ~core_clk;
  pirq_router i_pirq_router (.core_clk(core_clk), .rst(rst), .uart_tx_request(req[5:0]),
    .uart_rx_request(req[11:6]), .uart_tx_overrun_request(req[17:12]),
    .uart_rx_overrun_request(req[23:18]), .uart_combined_request(req[29:24]),
    .gpio_combined_request(req[33:30]), .gpio0_pin_request(req[49:34]),
    .gpio1_pin_request(req[65:50]), .gpio2_pin_request(req[81:66]),
    .gpio3_pin_request(req[97:82]), .watchdog_request(req[98]), .timer1_request(req[99]),
    .timer2_request(req[100]), .timer_combined_request(req[101]), .rtc_request(req[102]),
    .ethernet_request(req[103]), .usb_request(req[104]), .audio_request(req[105]),
    .touch_request(req[106]), .adc_spi_request(req[107]), .shield0_spi_request(req[108]),
    .shield1_spi_request(req[109]), .lcd_request(req[110]), .shared_irq(shared_irq),
    .private_irq_group0_n(private_irq_group0_n), .private_irq_group1_n(private_irq_group1_n));
  pirq_ctrl_model i_pirq_ctrl_model (.shared_irq(shared_irq), .pending(pending),
    .private_irq_group0_n(private_irq_group0_n), .private_irq_group1_n(private_irq_group1_n));
  ////////////////////////////////////////////////////////////////////////////////////////////
  // expected pending flags worked out from the line map
  function automatic logic [135:0] expect_lines();
    logic [127:0] s;
    logic [5:0]   o;
    o = req[17:12] | req[23:18];
    s = '0;
    s[4:0] = req[102:98];
    s[25:18] = req[110:103];
    for (int n = 2; n < 6; n++) s[2*n+1 +: 2] = {req[n], req[6+n]};
    s[17:13] = {|o[5:2], req[29:26]};
    s[93:26] = {req[97:34], req[33:30]};
    return {o[1], req[25], req[1], req[7], o[0], req[24], req[0], req[6], s};
  endfunction
  task automatic cmp(input logic [135:0] e);
    samples_checked++;
    if (pending !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, pending);
    end
  endtask
  // three-flop latency, judged at the falling edge once it has landed
  task automatic settle_check();
    logic [135:0] e;
    e = expect_lines();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    cmp(e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  // one source at a time, so a swapped or shared line shows up
  task automatic t_walk();
    for (int i = 0; i < 111; i++) begin
      @(negedge core_clk);
      req = 111'h1 << i;
      settle_check();
    end
  endtask
  // both overruns together must still raise the overflow line
  task automatic t_overrun_pair();
    for (int n = 0; n < 6; n++) begin
      @(negedge core_clk);
      req = (111'h1 << (12 + n)) | (111'h1 << (18 + n));
      settle_check();
    end
  endtask
  task automatic t_all_high();
    @(negedge core_clk);
    req = '1;
    settle_check();
    req = '0;
    settle_check();
  endtask
  // the controller base handed to software must be the documented one
  task automatic t_ctrl_base();
    samples_checked++;
    if (i_pirq_router.CTRL_BASE !== 32'hF000_0000) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, 32'hF000_0000, i_pirq_router.CTRL_BASE);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge core_clk);
    cmp('0);
    t_ctrl_base();
    rst = 1'b0;
    t_walk();
    t_overrun_pair();
    t_all_high();
    complete_run();
  end
  // hang guard
  initial begin
    #1000000;
    errors++;
    complete_run();
  end
endmodule // pirq_router_tb
bind pirq_router pirq_router_monitor #(.NUM_UART(NUM_UART), .GPIO_PINS(GPIO_PINS),
  .SHARED_W(SHARED_W)) i_pirq_router_monitor (
  .uart_tx_request         (uart_tx_request),
  .uart_rx_request         (uart_rx_request),
  .uart_tx_overrun_request (uart_tx_overrun_request),
  .uart_rx_overrun_request (uart_rx_overrun_request),
  .uart_combined_request   (uart_combined_request),
  .gpio_combined_request   (gpio_combined_request),
  .gpio0_pin_request       (gpio0_pin_request),
  .gpio1_pin_request       (gpio1_pin_request),
  .gpio2_pin_request       (gpio2_pin_request),
  .gpio3_pin_request       (gpio3_pin_request),
  .shared_irq              (shared_irq),
  .private_irq_group0_n    (private_irq_group0_n),
  .private_irq_group1_n    (private_irq_group1_n),
  .core_clk                (core_clk),
  .rst                     (rst));
`default_nettype wire
